//--- common/pst_cfg.svh
// Offsets, field positions, reset values and timing figures of one port's power-save and test logic.
// Included by the port module only; holds definitions and nothing else.
`ifndef PST_CFG_SVH
`define PST_CFG_SVH

// Register byte offsets
`define PST_OFF_CTRL 8'h00
`define PST_OFF_TIMER 8'h04
`define PST_OFF_GEN 8'h08
`define PST_OFF_GADDR 8'h0C
`define PST_OFF_STAT 8'h10
`define PST_OFF_CNT 8'h14

// Control register fields
`define PST_CTRL_PSAVE 0
`define PST_CTRL_ANEG 1
`define PST_CTRL_LOCAL 2
`define PST_CTRL_REMOTE 3
`define PST_CTRL_PDOWN 4
`define PST_CTRL_RST 32'h0000_0003

// Timer register fields
`define PST_TMR_SLEEP_LO 0
`define PST_TMR_WAKE_LO 3
`define PST_TMR_LINKH_LO 5
`define PST_TMR_LINKL_LO 7
`define PST_TMR_RST 32'h0000_0111

// Generator register fields
`define PST_GEN_ENA 0
`define PST_GEN_RUN 1
`define PST_GEN_DUR 2
`define PST_GEN_BADFCS 3
`define PST_GEN_GAP_LO 8
`define PST_GEN_LEN_LO 16
`define PST_GEN_RST 32'h0040_0C00
`define PST_GADDR_RST 32'h0000_0000

// Time figures
`define PST_CLK_PERIOD_NS 25
`define PST_MS_NS 1000000
`define PST_SLEEP_STEP_MS 1000
`define PST_SLEEP_NEG_MS 80
`define PST_SLEEP_POS_MS 60
`define PST_WAKE_STEP_MS 16
`define PST_BURST_GAP_MS 16
`define PST_BURST_MAX 3
`define PST_LINK_STEP_MS 125
`define PST_PKT_LIMIT 30000000

// Bus answers
`define PST_RESP_OKAY 2'b00
`define PST_RESP_SLVERR 2'b10

`endif

//--- common/pst_pkg.sv
// Types shared by the port power-save and test logic and its bench.
// Assumes nothing of its surroundings.
package pst_pkg;

  // Power-save states
  typedef enum logic [1:0] {
    PST_ST_LOW    = 2'b00,
    PST_ST_WAKE   = 2'b01,
    PST_ST_NORMAL = 2'b10
  } pst_state_t;

  // Packet generator states
  typedef enum logic [1:0] {
    PST_G_IDLE  = 2'b00,
    PST_G_FRAME = 2'b01,
    PST_G_GAP   = 2'b10
  } pst_gen_t;

  // One byte of a frame stream
  typedef struct packed {
    logic vld;
    logic [7:0] dat;
    logic last;
    logic err;
  } pst_byte_t;

endpackage : pst_pkg

//--- hdl/pst_port.sv
// Per-port power-save state machine, packet generator, CRC counters and loopback paths.
// Assumes an AXI4-Lite master on core_clk_i, a PCS byte stream on both sides, and an async energy pin.
//
// Function
// [RL1] Per-port enable bit starts power saving
// [RL2] Three states: low, wake-up, normal
// [RL3] Alternate low/wake until energy; default two seconds
// [RL4] Energy detected moves port to normal
// [RL5] Link loss with autoneg times out to low
// [RL6] Reset starts in low power
// [RL7] Forced speed: cycle, then stay normal
// [RL8] Autoneg off in normal: stay normal
// [RL9] Low power: digital off, detector on
// [RL10] Sleep dwell randomly offset -80/+60 ms; code: first dwell after reset is a fixed 2000 ms
// [RL11] Wake-up: three bursts, pairs A/B alternate; code: one burst at wake setting 0, two at 1
// [RL12] After wake-up energy, back to low
// [RL13] Generator enabled: sole transmit source; code: remote or local turnaround overrides the generator on media_tx_o
// [RL14] Run bit starts configured packet stream
// [RL15] Duration zero: run clears after 30M packets
// [RL16] 14-bit good CRC packet counter
// [RL17] 8-bit bad CRC packet counter
// [RL18] Remote turnaround retransmits received data
// [RL19] Remote turnaround: MAC still receives, transmit dropped
// [RL20] Local turnaround loops MAC transmit to receive
// [RL21] Local turnaround transmits nothing on media
// [RL22] Per-port seeded free-running random source
`timescale 1ns/1ps
`include "pst_cfg.svh"

module pst_port
  import pst_pkg::*;
#(
  parameter int MS_CYCLES = `PST_MS_NS / `PST_CLK_PERIOD_NS,
  parameter int PKT_LIMIT = `PST_PKT_LIMIT,
  parameter logic [15:0] LFSR_SEED = 16'hACE1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Media side
  input wire logic energy_pin_i,
  input wire logic link_up_i,
  input wire pst_byte_t media_rx_i,
  output pst_byte_t media_tx_o,
  output logic flp_burst_a_o,
  output logic flp_burst_b_o,
  // MAC side
  input wire pst_byte_t mac_tx_i,
  output pst_byte_t mac_rx_o,
  // Power control
  output logic digital_power_down_o,
  output logic energy_detect_on_o,
  output pst_state_t psave_state_o
);

  // Elaboration checks
  if (MS_CYCLES < 1) begin : g_chk_ms
    $error("MS_CYCLES must be at least one");
  end
  if (PKT_LIMIT < 1 || PKT_LIMIT > 33554431) begin : g_chk_pkt
    $error("PKT_LIMIT must fit 25 bits");
  end
  if (LFSR_SEED == 16'h0000) begin : g_chk_seed
    $error("LFSR_SEED must be non-zero");
  end

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] stb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Software registers
  logic [31:0] ctrl_r; // Power save, autoneg, turnarounds
  logic [31:0] timer_r; // Sleep, wake, link-loss settings
  logic [31:0] gen_r; // Generator controls
  logic [31:0] gaddr_r; // Generator addresses and pattern
  logic [13:0] good_crc_packet_count;
  logic [7:0] bad_crc_packet_count;

  // Field views
  logic auto_power_save_enable;
  logic aneg_en;
  logic local_turnaround_enable;
  logic remote_turnaround_enable;
  logic standard_powerdown_bit;
  logic [2:0] sleep_interval_setting;
  logic [1:0] wake_setting;
  logic [1:0] link_loss_timeout_high;
  logic [1:0] link_loss_timeout_low;
  logic generator_enable;
  logic generator_run;
  logic gen_continuous;
  logic gen_bad_fcs;
  logic [7:0] gen_gap;
  logic [11:0] gen_len;
  assign auto_power_save_enable = ctrl_r[`PST_CTRL_PSAVE];
  assign aneg_en = ctrl_r[`PST_CTRL_ANEG];
  assign local_turnaround_enable = ctrl_r[`PST_CTRL_LOCAL];
  assign remote_turnaround_enable = ctrl_r[`PST_CTRL_REMOTE];
  assign standard_powerdown_bit = ctrl_r[`PST_CTRL_PDOWN];
  assign sleep_interval_setting = timer_r[`PST_TMR_SLEEP_LO +: 3];
  assign wake_setting = timer_r[`PST_TMR_WAKE_LO +: 2];
  assign link_loss_timeout_high = timer_r[`PST_TMR_LINKH_LO +: 2];
  assign link_loss_timeout_low = timer_r[`PST_TMR_LINKL_LO +: 2];
  assign generator_enable = gen_r[`PST_GEN_ENA];
  assign generator_run = gen_r[`PST_GEN_RUN];
  assign gen_continuous = gen_r[`PST_GEN_DUR];
  assign gen_bad_fcs = gen_r[`PST_GEN_BADFCS];
  assign gen_gap = gen_r[`PST_GEN_GAP_LO +: 8];
  assign gen_len = gen_r[`PST_GEN_LEN_LO +: 12];

  // ---------------- AXI4-Lite slave ----------------
  logic aw_got_r; // Address held, awaiting data
  logic w_got_r; // Data held, awaiting address
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire; // One-cycle write commit
  logic run_clear; // Generator finished its packet budget
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

  // Write address channel
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b0;
      aw_got_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_got_r <= 1'b0;
    end else if (!aw_got_r) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_wready <= 1'b0;
      w_got_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_got_r <= 1'b0;
    end else if (!w_got_r) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; unmapped or read-only offsets answer SLVERR
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PST_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_r == `PST_OFF_CTRL || awaddr_r == `PST_OFF_TIMER || awaddr_r == `PST_OFF_GEN ||
                      awaddr_r == `PST_OFF_GADDR) ? `PST_RESP_OKAY : `PST_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control, timer and generator address registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_r <= `PST_CTRL_RST;
      timer_r <= `PST_TMR_RST;
      gaddr_r <= `PST_GADDR_RST;
    end else if (wr_fire) begin
      if (awaddr_r == `PST_OFF_CTRL) begin // RL1
        ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_001F;
      end
      if (awaddr_r == `PST_OFF_TIMER) begin
        timer_r <= merge(timer_r, wdata_r, wstrb_r) & 32'h0000_01FF;
      end
      if (awaddr_r == `PST_OFF_GADDR) begin
        gaddr_r <= merge(gaddr_r, wdata_r, wstrb_r) & 32'h00FF_FFFF;
      end
    end
  end

  // Generator register; a software write of run wins over the automatic clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gen_r <= `PST_GEN_RST;
    end else if (wr_fire && awaddr_r == `PST_OFF_GEN) begin
      gen_r <= merge(gen_r, wdata_r, wstrb_r) & 32'h0FFF_FF0F;
    end else if (run_clear) begin
      gen_r[`PST_GEN_RUN] <= 1'b0; // RL15
    end
  end

  // Read channel; data captured when the address is taken
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `PST_OFF_CTRL: rd_mux = ctrl_r;
      `PST_OFF_TIMER: rd_mux = timer_r;
      `PST_OFF_GEN: rd_mux = gen_r;
      `PST_OFF_GADDR: rd_mux = gaddr_r;
      `PST_OFF_STAT: rd_mux = {28'h0000000, link_up_i, energy_detect_on_o, psave_state_o};
      `PST_OFF_CNT: rd_mux = {8'h00, bad_crc_packet_count, 2'b00, good_crc_packet_count}; // RL16 RL17
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PST_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `PST_RESP_OKAY : `PST_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= !s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- Energy pin synchroniser ----------------
  logic en_s1_r, en_s2_r, en_s3_r, energy_r;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      en_s3_r <= 1'b0;
      energy_r <= 1'b0;
    end else begin
      en_s1_r <= energy_pin_i;
      en_s2_r <= en_s1_r;
      en_s3_r <= en_s2_r;
      if (en_s2_r == en_s3_r) begin
        energy_r <= en_s3_r; // Glitch shorter than a cycle never counts
      end
    end
  end

  // ---------------- Millisecond tick and random source ----------------
  logic [31:0] ms_cnt_r;
  logic ms_tick;
  logic [15:0] lfsr_r;
  assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ms_cnt_r <= 32'h0000_0000;
    end else begin
      ms_cnt_r <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
    end
  end

  // Free-running per-port sequence; seed differs per port so ports never lock step
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lfsr_r <= LFSR_SEED; // RL22
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  // ---------------- Power-save state machine ----------------
  logic [13:0] base_ms; // Programmed dwell
  logic [7:0] rnd_off; // 0..140, maps to -80..+60
  logic [13:0] dwell_ms_r; // Current dwell with offset
  logic [13:0] tmr_ms_r; // Elapsed ms in current state
  logic [1:0] burst_cnt_r;
  logic [6:0] wake_ms;
  logic [10:0] link_ms; // Up to 2000 ms, needs 11 bits
  logic forced_r; // Normal entered without autoneg
  pst_state_t st_r;
  assign base_ms = 14'(`PST_SLEEP_STEP_MS * (32'(sleep_interval_setting) + 1));
  assign rnd_off = (lfsr_r[7:0] > 8'h8C) ? 8'(lfsr_r[7:0] - 8'h8D) : lfsr_r[7:0];
  assign wake_ms = 7'(`PST_WAKE_STEP_MS * (32'(wake_setting) + 1));
  assign link_ms = 11'(`PST_LINK_STEP_MS * (32'({link_loss_timeout_high, link_loss_timeout_low}) + 1)); // RL5

  // State transitions and timers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= PST_ST_LOW; // RL6
      tmr_ms_r <= 14'h0000;
      dwell_ms_r <= 14'(`PST_SLEEP_STEP_MS * 2);
      forced_r <= 1'b0;
    end else if (!auto_power_save_enable) begin
      st_r <= PST_ST_NORMAL; // Feature off: port stays powered
      tmr_ms_r <= 14'h0000;
      forced_r <= 1'b0;
    end else begin
      case (st_r) // RL2
        PST_ST_LOW: begin
          if (energy_r) begin
            st_r <= PST_ST_NORMAL; // RL4
            tmr_ms_r <= 14'h0000;
            forced_r <= !aneg_en; // RL7
          end else if (ms_tick && tmr_ms_r >= dwell_ms_r) begin
            st_r <= PST_ST_WAKE; // RL3
            tmr_ms_r <= 14'h0000;
          end else if (ms_tick) begin
            tmr_ms_r <= tmr_ms_r + 14'h0001;
          end
        end
        PST_ST_WAKE: begin
          if (energy_r) begin
            st_r <= PST_ST_NORMAL; // RL4
            tmr_ms_r <= 14'h0000;
            forced_r <= !aneg_en;
          end else if (ms_tick && tmr_ms_r >= 14'(wake_ms)) begin
            st_r <= PST_ST_LOW; // RL12
            tmr_ms_r <= 14'h0000;
            dwell_ms_r <= base_ms + 14'(rnd_off) - 14'(`PST_SLEEP_NEG_MS); // RL10
          end else if (ms_tick) begin
            tmr_ms_r <= tmr_ms_r + 14'h0001;
          end
        end
        PST_ST_NORMAL: begin
          if (link_up_i || !aneg_en || forced_r) begin
            tmr_ms_r <= 14'h0000; // RL8
          end else if (ms_tick && tmr_ms_r >= 14'(link_ms)) begin
            st_r <= PST_ST_LOW; // RL5
            tmr_ms_r <= 14'h0000;
            dwell_ms_r <= base_ms + 14'(rnd_off) - 14'(`PST_SLEEP_NEG_MS);
          end else if (ms_tick) begin
            tmr_ms_r <= tmr_ms_r + 14'h0001;
          end
        end
        default: begin
          st_r <= PST_ST_LOW;
        end
      endcase
    end
  end

  // Wake-up bursts, one per burst slot, alternating pair A and pair B
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      burst_cnt_r <= 2'b00;
      flp_burst_a_o <= 1'b0;
      flp_burst_b_o <= 1'b0;
    end else begin
      flp_burst_a_o <= 1'b0;
      flp_burst_b_o <= 1'b0;
      if (st_r != PST_ST_WAKE) begin
        burst_cnt_r <= 2'b00;
      end else if (ms_tick && tmr_ms_r[3:0] == 4'h0 && burst_cnt_r < 2'(`PST_BURST_MAX)
                   && tmr_ms_r < 14'(wake_ms)) begin
        burst_cnt_r <= burst_cnt_r + 2'b01; // RL11
        flp_burst_a_o <= !burst_cnt_r[0];
        flp_burst_b_o <= burst_cnt_r[0];
      end
    end
  end

  // Power outputs; detector never turns off
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      digital_power_down_o <= 1'b1;
      energy_detect_on_o <= 1'b1;
      psave_state_o <= PST_ST_LOW;
    end else begin
      digital_power_down_o <= (st_r == PST_ST_LOW) || standard_powerdown_bit; // RL9
      energy_detect_on_o <= 1'b1;
      psave_state_o <= st_r;
    end
  end

  // ---------------- Packet generator ----------------
  pst_gen_t gst_r;
  logic [11:0] idx_r; // Byte index in frame or gap
  logic [24:0] pkt_cnt_r;
  pst_byte_t gen_byte;
  always_comb begin
    gen_byte = '0;
    if (gst_r == PST_G_FRAME) begin
      gen_byte.vld = 1'b1;
      gen_byte.dat = (idx_r < 12'h006) ? gaddr_r[7:0] : (idx_r < 12'h00C) ? gaddr_r[15:8] : gaddr_r[23:16];
      gen_byte.last = (idx_r == gen_len - 12'h001);
      gen_byte.err = gen_byte.last && gen_bad_fcs; // Bad FCS flagged on last byte
    end
  end
  assign run_clear = !gen_continuous && (pkt_cnt_r == 25'(PKT_LIMIT));

  // Frame, gap, and packet budget
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gst_r <= PST_G_IDLE;
      idx_r <= 12'h000;
      pkt_cnt_r <= 25'h0000000;
    end else begin
      case (gst_r)
        PST_G_IDLE: begin
          idx_r <= 12'h000;
          if (generator_enable && generator_run && !run_clear) begin
            gst_r <= PST_G_FRAME; // RL14
          end
          if (!generator_run) begin
            pkt_cnt_r <= 25'h0000000;
          end
        end
        PST_G_FRAME: begin
          if (gen_byte.last) begin
            gst_r <= PST_G_GAP;
            idx_r <= 12'h000;
            if (!gen_continuous && pkt_cnt_r < 25'(PKT_LIMIT)) begin
              pkt_cnt_r <= pkt_cnt_r + 25'h0000001; // Saturates; continuous mode never spends the budget
            end
          end else begin
            idx_r <= idx_r + 12'h001;
          end
        end
        PST_G_GAP: begin
          if (idx_r >= 12'(gen_gap)) begin
            gst_r <= PST_G_IDLE; // Finished frames are never cut short
          end else begin
            idx_r <= idx_r + 12'h001;
          end
        end
        default: begin
          gst_r <= PST_G_IDLE;
        end
      endcase
    end
  end

  // ---------------- Data paths ----------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      media_tx_o <= '0;
      mac_rx_o <= '0;
    end else if (local_turnaround_enable) begin
      media_tx_o <= '0; // RL21
      mac_rx_o <= mac_tx_i; // RL20
    end else begin
      mac_rx_o <= media_rx_i; // RL19
      if (remote_turnaround_enable) begin
        media_tx_o <= media_rx_i; // RL18
      end else if (generator_enable) begin
        media_tx_o <= gen_byte; // RL13
      end else begin
        media_tx_o <= mac_tx_i;
      end
    end
  end

  // CRC counters on the MAC-side receive stream, wrapping
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      good_crc_packet_count <= 14'h0000;
      bad_crc_packet_count <= 8'h00;
    end else if (mac_rx_o.vld && mac_rx_o.last) begin
      if (mac_rx_o.err) begin
        bad_crc_packet_count <= bad_crc_packet_count + 8'h01; // RL17
      end else begin
        good_crc_packet_count <= good_crc_packet_count + 14'h0001; // RL16
      end
    end
  end

  // ---------------- Assertions ----------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_reset_low;
    $past(rst_i) |-> st_r == PST_ST_LOW;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("state not low after reset"); // RL6

  property p_energy_wakes;
    auto_power_save_enable && st_r != PST_ST_NORMAL && energy_r ##1 auto_power_save_enable |-> st_r == PST_ST_NORMAL;
  endproperty
  a_energy_wakes: assert property (p_energy_wakes) else $error("energy did not reach normal"); // RL4

  property p_no_aneg_stays;
    st_r == PST_ST_NORMAL && !aneg_en |=> st_r == PST_ST_NORMAL;
  endproperty
  a_no_aneg_stays: assert property (p_no_aneg_stays) else $error("left normal without autoneg"); // RL8

  property p_link_timeout;
    auto_power_save_enable && st_r == PST_ST_NORMAL ##1 st_r == PST_ST_LOW |-> $past(aneg_en) && !$past(link_up_i);
  endproperty
  a_link_timeout: assert property (p_link_timeout) else $error("low entered with link or no autoneg"); // RL5

  property p_low_power;
    st_r == PST_ST_LOW |=> digital_power_down_o && energy_detect_on_o;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low state not powered down"); // RL9

  property p_dwell_range;
    st_r == PST_ST_LOW |-> dwell_ms_r >= base_ms - 14'(`PST_SLEEP_NEG_MS)
                          && dwell_ms_r <= base_ms + 14'(`PST_SLEEP_POS_MS);
  endproperty
  a_dwell_range: assert property (p_dwell_range) else $error("sleep dwell out of range"); // RL10

  property p_local_silent;
    local_turnaround_enable |=> !media_tx_o.vld && mac_rx_o == $past(mac_tx_i);
  endproperty
  a_local_silent: assert property (p_local_silent) else $error("local turnaround path wrong"); // RL21

  property p_remote_echo;
    remote_turnaround_enable && !local_turnaround_enable |=> media_tx_o == $past(media_rx_i)
                                                             && mac_rx_o == $past(media_rx_i);
  endproperty
  a_remote_echo: assert property (p_remote_echo) else $error("remote turnaround path wrong"); // RL19

  property p_gen_source;
    generator_enable && !remote_turnaround_enable && !local_turnaround_enable |=> media_tx_o == $past(gen_byte);
  endproperty
  a_gen_source: assert property (p_gen_source) else $error("generator not sole source"); // RL13

  property p_pkt_budget;
    !gen_continuous |-> pkt_cnt_r <= 25'(PKT_LIMIT);
  endproperty
  a_pkt_budget: assert property (p_pkt_budget) else $error("packet budget exceeded"); // RL15

  property p_good_count;
    mac_rx_o.vld && mac_rx_o.last && !mac_rx_o.err |=>
      good_crc_packet_count == $past(good_crc_packet_count) + 14'h0001;
  endproperty
  a_good_count: assert property (p_good_count) else $error("good CRC count missed"); // RL16

  c_low_to_wake: cover property (st_r == PST_ST_LOW ##1 st_r == PST_ST_WAKE);
  c_wake_to_low: cover property (st_r == PST_ST_WAKE ##1 st_r == PST_ST_LOW);
  c_normal: cover property (st_r == PST_ST_WAKE ##1 st_r == PST_ST_NORMAL);
  c_run_done: cover property (generator_run ##1 !generator_run);

endmodule : pst_port

//--- tb/pst_lp.sv
// Link partner model: four-byte frames and signal energy.
// Assumes one-cycle go pulses on clk_i.
`timescale 1ns/1ps
module pst_lp
  import pst_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic bad_i,
  input wire logic energy_i,
  output logic energy_o,
  output pst_byte_t rx_o
);
  int n = 0; // Bytes left
  int t = 0; // Idle pattern
  // Idle data changes every cycle
  always @(posedge clk_i) begin
    t <= t + 1;
    energy_o <= energy_i;
    n <= go_i ? 4 : (n > 0 ? n - 1 : 0);
    rx_o <= '{n > 0, n > 0 ? 8'(n) : 8'(t), n == 1, n == 1 && bad_i};
  end
endmodule : pst_lp

//--- tb/pst_port_bench.sv
// Bench for one port: bus tasks, power save, turnaround, generator.
// Assumes shortened ms and packet counts.
`timescale 1ns/1ps
module pst_port_bench
  import pst_pkg::*;
;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, go = 0, bad = 0, en = 0, lk = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wdt = 0, rd;
  logic awr, wr, bv, arr, rv, fa, fb, dpd, edo, egy;
  logic [1:0] br, rr;
  pst_byte_t rxw, mtx, mrx, p, mti = '0;
  pst_state_t st;
  int miscompares = 0, check_count = 0, na = 0, nb = 0, c, i, k, m;
  // Clock and burst counting
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    na <= na + fa;
    nb <= nb + fb;
  end
  pst_port #(.MS_CYCLES(4), .PKT_LIMIT(3)) pst_port_i (.core_clk_i(clk), .rst_i(rst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdt), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .energy_pin_i(egy), .link_up_i(lk), .media_rx_i(rxw), .media_tx_o(mtx),
    .flp_burst_a_o(fa), .flp_burst_b_o(fb), .mac_tx_i(mti), .mac_rx_o(mrx), .digital_power_down_o(dpd),
    .energy_detect_on_o(edo), .psave_state_o(st));
  pst_lp pst_lp_i (.clk_i(clk), .go_i(go), .bad_i(bad), .energy_i(en), .energy_o(egy), .rx_o(rxw));
  task automatic chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %0h want %0h", $time, s, e);
    end
  endtask : chk
  // One bus access; holds each channel until taken
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    awv <= w; wv <= w; arv <= !w; awa <= a; ara <= a; wdt <= d; bry <= 1; rry <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
      if (arr) arv <= 0;
    end while (!(w ? bv : rv));
    bry <= 0; rry <= 0;
    chk(w ? br : rr, e);
    if (!w) chk(rd, d);
  endtask : ax
  task automatic wst(input pst_state_t s, input int n);
    for (c = 0; c < n && st !== s; c++) @(posedge clk);
    chk(st, s);
  endtask : wst
  task automatic frm(input logic b);
    bad <= b; go <= 1;
    @(posedge clk);
    go <= 0;
  endtask : frm
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    ax(0, 8'h00, 32'h3, 0);
    ax(0, 8'h04, 32'h111, 0);
    ax(0, 8'h08, 32'h0040_0C00, 0);
    ax(0, 8'h0C, 0, 0);
    ax(0, 8'h20, 0, 2); // Unmapped
    ax(1, 8'h14, 5, 2); // Read-only
    chk({dpd, edo, st}, 4'hC);
    $display("reset test done");
    wst(PST_ST_WAKE, 9000);
    wst(PST_ST_LOW, 400);
    wst(PST_ST_WAKE, 9000);
    chk(c >= 7676 && c <= 8244, 1);
    wst(PST_ST_LOW, 400);
    chk({na[7:0], nb[7:0]}, 16'h0402);
    en <= 1; lk <= 1;
    wst(PST_ST_NORMAL, 20);
    @(posedge clk);
    chk(dpd, 0);
    en <= 0; lk <= 0;
    wst(PST_ST_LOW, 1700);
    chk(c >= 1480, 1);
    ax(1, 8'h00, 32'h1, 0);
    en <= 1;
    wst(PST_ST_NORMAL, 20);
    en <= 0;
    ax(1, 8'h00, 32'h3, 0);
    repeat (1700) @(posedge clk);
    chk(st, PST_ST_NORMAL);
    ax(1, 8'h00, 32'h2, 0);
    ax(1, 8'h00, 32'h3, 0);
    ax(1, 8'h00, 32'h11, 0);
    repeat (2000) @(posedge clk);
    chk(st, PST_ST_NORMAL);
    chk(dpd, 1); // Standard power-down bit
    $display("power save test done");
    ax(1, 8'h00, 32'h8, 0);
    mti <= '{1'b1, 8'hA5, 1'b0, 1'b0};
    frm(0);
    for (i = 0; i < 8; i++) begin
      p = rxw;
      @(posedge clk);
      chk(mtx, p);
      chk(mrx, p);
    end
    frm(1);
    repeat (8) @(posedge clk);
    ax(0, 8'h14, 32'h0001_0001, 0);
    ax(1, 8'h00, 32'h4, 0);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      chk(mrx, mti);
      chk(mtx.vld, 0);
    end
    $display("turnaround test done");
    ax(1, 8'h00, 32'h0, 0);
    ax(1, 8'h0C, 32'h11, 0);
    ax(1, 8'h08, 32'h0004_020B, 0);
    m = 0; k = 0;
    i = 0;
    repeat (200) begin
      @(posedge clk);
      m += mtx.vld; k += mtx.vld & mtx.last;
      i += mtx.err;
      if (mtx.vld) chk(mtx.dat, 8'h11);
    end
    chk({m[7:0], k[7:0]}, 16'h0C03);
    chk(i, 3);
    ax(0, 8'h08, 32'h0004_0209, 0);
    $display("generator test done");
    results();
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule : pst_port_bench
